// [bench/spi_peer.sv]
// Peer slave model that answers the port while the port is master.
// Assumes polarity 0, phase 1, MSB first; the bench resolves the pad wires.
`timescale 1ns/1ps
module spi_peer (
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic [7:0] i_tx,
   output logic            o_miso,
   output logic [7:0]      o_rx
);
   int idx = 0;
   // Idle answer line before the first frame
   initial begin
      o_miso = 1'b0;
   end
   // Leading edge presents the next answer bit
   always @(posedge i_sck) begin
      o_miso <= i_tx[7-idx];
   end
   // Trailing edge samples; after the eighth bit the answer line is inverted
   always @(negedge i_sck) begin
      o_rx <= {o_rx[6:0], i_mosi};
      idx  <= (idx == 7) ? 0 : idx + 1;
      if (idx == 7) begin
         o_miso <= ~o_miso;
      end
   end
endmodule

// [bench/tb.sv]
// Self-checking bench: AXI4-Lite master, pad resolution and a peer slave.
// Assumes the port decodes offsets from the shared package.
`timescale 1ns/1ps
module tb;
   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic [3:0]  awaddr  = 4'h0;
   logic        awvalid = 1'b0;
   logic [31:0] wdata   = 32'h0;
   logic        wvalid  = 1'b0;
   logic        bready  = 1'b0;
   logic [3:0]  araddr  = 4'h0;
   logic        arvalid = 1'b0;
   logic        rready  = 1'b0;
   logic        ss_drv  = 1'b1;
   logic        sck_drv = 1'b0;
   logic        mosi_drv = 1'b1;
   logic [7:0]  peer_tx = 8'h00;
   logic        awready, wready, bvalid, arready, rvalid, sck_q;
   logic [1:0]  bresp, rresp;
   logic [31:0] rdata;
   logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
   logic        rx_irq, tx_irq, err_irq, peer_miso;
   logic [7:0]  peer_rx;
   int          errors = 0;
   int          cmp_count = 0;
   int          half = 0;
   int          run = 0;
   wire         sck_w  = sck_oe ? sck_o : sck_drv;
   wire         mosi_w = mosi_oe ? mosi_o : mosi_drv;
   wire         miso_w = miso_oe ? miso_o : peer_miso;
   wire         ss_w   = ss_oe ? ss_o : ss_drv;

   spi_select_control_status #(.ADDR_W(4)) dut_u (
      .i_ref_clk(ref_clk), .i_rst(rst),
      .i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready),
      .i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'hF), .i_s_axi_wvalid(wvalid),
      .o_s_axi_wready(wready), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid),
      .i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
      .o_s_axi_arready(arready), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
      .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .i_serial_clock_pin(sck_w), .o_serial_clock_pin(sck_o),
      .o_serial_clock_pin_oe(sck_oe), .i_mosi(mosi_w), .o_mosi(mosi_o),
      .o_mosi_oe(mosi_oe), .i_miso(miso_w), .o_miso(miso_o), .o_miso_oe(miso_oe),
      .i_ss_n(ss_w), .o_ss_n(ss_o), .o_ss_n_oe(ss_oe),
      .o_rx_irq(rx_irq), .o_tx_irq(tx_irq), .o_err_irq(err_irq)
   );
   spi_peer peer_u (.i_sck(sck_w), .i_mosi(mosi_w), .i_tx(peer_tx), .o_miso(peer_miso),
      .o_rx(peer_rx));

   // Module clock, 25 ns period
   initial begin
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Cycles between serial clock changes
   always @(posedge ref_clk) begin
      sck_q <= sck_o;
      if (sck_o !== sck_q) begin
         half <= run;
         run  <= 1;
      end else begin
         run <= run + 1;
      end
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d, output logic [1:0] r);
      awaddr  <= a;
      wdata   <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge ref_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      logic [1:0] r;
      wr(a, d, r);
      chk("bresp", spi_pkg::RESP_OKAY, r);
   endtask
   task automatic rchk(input string what, input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0]  r;
      rd(a, d, r);
      chk(what, exp, d);
   endtask
   task automatic wait_flag(input logic ovf);
      while ((ovf ? err_irq : rx_irq) !== 1'b1) @(posedge ref_clk);
   endtask

   task automatic reset_values;
      chk("tx_irq", 1'b0, tx_irq);
      rchk("ctrl", spi_pkg::CTRL_OFF, 32'h28);
      rchk("stat", spi_pkg::STAT_OFF, 32'h08);
      wreg(spi_pkg::CTRL_OFF, 8'h68);
      rchk("dma", spi_pkg::CTRL_OFF, 32'h28);
   endtask
   task automatic unmapped_access;
      logic [31:0] d;
      logic [1:0]  r;
      wr(4'h2, 8'hFF, r);
      chk("bresp", spi_pkg::RESP_SLVERR, r);
      rd(4'h3, d, r);
      chk("rresp", spi_pkg::RESP_SLVERR, r);
      chk("rdata", 32'h0, d);
      rchk("ctrl", spi_pkg::CTRL_OFF, 32'h28);
   endtask
   task automatic select_ownership;
      wreg(spi_pkg::CTRL_OFF, 8'h2A);
      wreg(spi_pkg::PORT_OFF, 8'h02);
      chk("ss_oe", 1'b1, ss_oe);
      chk("ss_o", 1'b0, ss_o);
      wreg(spi_pkg::PORT_OFF, 8'h00);
      wreg(spi_pkg::STAT_OFF, 8'h04);
      wreg(spi_pkg::PORT_OFF, 8'h02);
      chk("ss_oe", 1'b0, ss_oe);
      wreg(spi_pkg::CTRL_OFF, 8'h0A);
      chk("ss_oe", 1'b0, ss_oe);
      chk("miso_oe", 1'b0, miso_oe);
      ss_drv <= 1'b0;
      cyc(6);
      chk("miso_oe", 1'b1, miso_oe);
      ss_drv <= 1'b1;
      cyc(6);
      chk("miso_oe", 1'b0, miso_oe);
      wreg(spi_pkg::CTRL_OFF, 8'h08);
      chk("ss_oe", 1'b1, ss_oe);
      wreg(spi_pkg::PORT_OFF, 8'h00);
   endtask
   task automatic slave_exchange;
      logic [7:0] snd;
      logic [7:0] got;
      snd = 8'h3A;
      got = 8'h00;
      wreg(spi_pkg::CTRL_OFF, 8'h02);
      wreg(spi_pkg::DATA_OFF, 8'h96);
      ss_drv <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_drv <= snd[i];
         cyc(6);
         got[i] = miso_w;
         sck_drv <= 1'b1;
         cyc(8);
         sck_drv <= 1'b0;
         cyc(2);
      end
      cyc(8);
      ss_drv <= 1'b1;
      cyc(6);
      chk("slave_tx", 8'h96, got);
      rchk("stat", spi_pkg::STAT_OFF, 32'h8C);
      rchk("slave_rx", spi_pkg::DATA_OFF, 32'h3A);
   endtask
   task automatic master_exchange;
      wreg(spi_pkg::STAT_OFF, 8'h41);
      wreg(spi_pkg::CTRL_OFF, 8'hAB);
      chk("tx_irq", 1'b1, tx_irq);
      peer_tx <= 8'h3C;
      wreg(spi_pkg::DATA_OFF, 8'hA5);
      rchk("stat", spi_pkg::STAT_OFF, 32'h49);
      wait_flag(1'b0);
      chk("peer_rx", 8'hA5, peer_rx);
      chk("half", 32'd8, half);
      rchk("stat", spi_pkg::STAT_OFF, 32'hC9);
      rchk("data", spi_pkg::DATA_OFF, 32'h3C);
      cyc(2);
      chk("rx_irq", 1'b0, rx_irq);
      peer_tx <= 8'hC3;
      wreg(spi_pkg::DATA_OFF, 8'h5A);
      wait_flag(1'b0);
      wreg(spi_pkg::DATA_OFF, 8'h77);
      wait_flag(1'b1);
      rchk("stat", spi_pkg::STAT_OFF, 32'hE9);
      rchk("data", spi_pkg::DATA_OFF, 32'hC3);
      rchk("stat", spi_pkg::STAT_OFF, 32'h49);
      chk("err_irq", 1'b0, err_irq);
   endtask
   task automatic mode_fault_cycle;
      wreg(spi_pkg::STAT_OFF, 8'h44);
      wreg(spi_pkg::CTRL_OFF, 8'h2A);
      ss_drv <= 1'b0;
      cyc(6);
      ss_drv <= 1'b1;
      cyc(4);
      chk("err_irq", 1'b1, err_irq);
      rchk("stat", spi_pkg::STAT_OFF, 32'h5C);
      rchk("ctrl", spi_pkg::CTRL_OFF, 32'h28);
      wreg(spi_pkg::STAT_OFF, 8'h40);
      rchk("stat", spi_pkg::STAT_OFF, 32'h58);
      wreg(spi_pkg::CTRL_OFF, 8'h2E);
      rchk("stat", spi_pkg::STAT_OFF, 32'h48);
      ss_drv <= 1'b0;
      cyc(6);
      ss_drv <= 1'b1;
      rchk("stat", spi_pkg::STAT_OFF, 32'h48);
      rchk("ctrl", spi_pkg::CTRL_OFF, 32'h2E);
   endtask
   task automatic disable_abort;
      wreg(spi_pkg::STAT_OFF, 8'h43);
      peer_tx <= 8'h55;
      wreg(spi_pkg::DATA_OFF, 8'hF0);
      cyc(40);
      chk("mosi_oe", 1'b0, mosi_oe);
      wreg(spi_pkg::CTRL_OFF, 8'h28);
      chk("sck_oe", 1'b0, sck_oe);
      rchk("stat", spi_pkg::STAT_OFF, 32'h4B);
      cyc(2200);
      rchk("stat", spi_pkg::STAT_OFF, 32'h4B);
   endtask

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // Main sequence after five reset cycles
   initial begin
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      reset_values;
      unmapped_access;
      select_ownership;
      slave_exchange;
      master_exchange;
      mode_fault_cycle;
      disable_abort;
      complete_run;
   end
   // Watchdog against a hang
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      complete_run;
   end
endmodule

// [common/spi_pkg.sv]
// Package: register map, field positions and reset values of the SPI port.
// Assumes an AXI4-Lite slave with 32-bit data; registers use the low byte.
package spi_pkg;
   // Register byte offsets
   localparam logic [3:0] CTRL_OFF = 4'h0;
   localparam logic [3:0] STAT_OFF = 4'h4;
   localparam logic [3:0] DATA_OFF = 4'h8;
   localparam logic [3:0] PORT_OFF = 4'hC;
   // Control register bits
   localparam int CTRL_RIE  = 7;
   localparam int CTRL_DMA  = 6;
   localparam int CTRL_MSTR = 5;
   localparam int CTRL_CPOL = 4;
   localparam int CTRL_CPHA = 3;
   localparam int CTRL_WOM  = 2;
   localparam int CTRL_EN   = 1;
   localparam int CTRL_TIE  = 0;
   localparam logic [7:0] CTRL_RESET = 8'h28;
   // Status and control register bits
   localparam int STAT_RF   = 7;
   localparam int STAT_EIE  = 6;
   localparam int STAT_OVF  = 5;
   localparam int STAT_MF   = 4;
   localparam int STAT_TE   = 3;
   localparam int STAT_MFEN = 2;
   localparam int STAT_RHI  = 1;
   localparam int STAT_RLO  = 0;
   // Slave select port register bits
   localparam int PORT_SS_OUT = 0;
   localparam int PORT_SS_DIR = 1;
   localparam int PORT_SS_PIN = 2;
   // Rate divisors, one half serial clock period in module clocks
   localparam logic [7:0] DIV_00 = 8'h02;
   localparam logic [7:0] DIV_01 = 8'h08;
   localparam logic [7:0] DIV_10 = 8'h20;
   localparam logic [7:0] DIV_11 = 8'h80;
   // Sixteen clock edges make one byte
   localparam logic [3:0] EDGE_LAST = 4'hF;
   // Bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [rtl/spi_select_control_status.sv]
// SPI port: control, status and slave select logic with a byte shifter.
// Assumes pins arrive unsynchronised; the pad wire is resolved outside.
// Functional notes
// R01 - CPHA0: master toggles select between bytes
// R02 - CPHA1: select may stay low across bytes
// R03 - Slave role: select pin always SPI input
// R04 - Select high: MISO off, clocks ignored
// R05 - Master without fault enable: select is GPIO
// R06 - Master with fault enable: select dedicated input
// R07 - Disabled: select is GPIO, ignored
// R08 - Receive and transmit enables gate requests
// R09 - DMA bit reads zero, no function
// R10 - Role bit: 1 master, reset master
// R11 - Polarity resets 0, phase resets 1
// R12 - Peer uses same polarity and phase
// R13 - Wired-OR makes outputs open drain
// R14 - Enable bit; clearing gives partial reset
// R15 - Receive full: set on byte, two-step clear
// R16 - Error enable gates fault and overflow
// R17 - Overflow keeps old byte, drops new
// R18 - Mode fault detection and two-step clear
// R19 - Disabled fault enable stops new faults
// R20 - Transmit empty sets on load, clears on write
// R21 - Software writes data only when empty
// R22 - Rate field picks divisor 2/8/32/128
// R23 - Disabled: abort, clear shifter, force empty
// R24 - Master mode fault clears enable bit
// R25 - Eight serial clocks exchange one byte
// R26 - Slave synchronises clock and select inputs
`timescale 1ns/1ps
module spi_select_control_status #(
   parameter int ADDR_W = 4
) (
   input  wire logic              i_ref_clk,
   input  wire logic              i_rst,
   input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
   input  wire logic              i_s_axi_awvalid,
   output logic                   o_s_axi_awready,
   input  wire logic [31:0]       i_s_axi_wdata,
   input  wire logic [3:0]        i_s_axi_wstrb,
   input  wire logic              i_s_axi_wvalid,
   output logic                   o_s_axi_wready,
   output logic [1:0]             o_s_axi_bresp,
   output logic                   o_s_axi_bvalid,
   input  wire logic              i_s_axi_bready,
   input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
   input  wire logic              i_s_axi_arvalid,
   output logic                   o_s_axi_arready,
   output logic [31:0]            o_s_axi_rdata,
   output logic [1:0]             o_s_axi_rresp,
   output logic                   o_s_axi_rvalid,
   input  wire logic              i_s_axi_rready,
   input  wire logic              i_serial_clock_pin,
   output logic                   o_serial_clock_pin,
   output logic                   o_serial_clock_pin_oe,
   input  wire logic              i_mosi,
   output logic                   o_mosi,
   output logic                   o_mosi_oe,
   input  wire logic              i_miso,
   output logic                   o_miso,
   output logic                   o_miso_oe,
   input  wire logic              i_ss_n,
   output logic                   o_ss_n,
   output logic                   o_ss_n_oe,
   output logic                   o_rx_irq,
   output logic                   o_tx_irq,
   output logic                   o_err_irq
);
   if (ADDR_W < 4) begin : g_chk
      $error("ADDR_W must be at least 4");
   end

   typedef struct packed {
      logic aw_hold; logic [ADDR_W-1:0] aw_addr; logic w_hold; logic [7:0] w_data;
      logic w_lane; logic awready; logic wready; logic bvalid; logic [1:0] bresp;
      logic arready; logic rvalid; logic [1:0] rresp; logic [7:0] rdata;
      logic [7:0] ctrl; logic eie; logic mfen; logic [1:0] rate;
      logic rf; logic ovf; logic mf; logic rf_arm; logic ovf_arm; logic mf_arm;
      logic ss_out; logic ss_dir; logic [7:0] tx_buf; logic tx_full;
      logic [7:0] rx_buf; logic [7:0] shift; logic active; logic [3:0] edge_cnt;
      logic [7:0] div_cnt; logic sck_lvl; logic in_bit; logic out_bit;
      logic [1:0] sck_sync; logic [1:0] ss_sync; logic [1:0] mosi_sync;
      logic [1:0] miso_sync; logic sck_prev; logic ss_prev;
      logic sck_o; logic sck_oe; logic mosi_o; logic mosi_oe; logic miso_o;
      logic miso_oe; logic ss_o; logic ss_oe; logic rx_irq; logic tx_irq; logic err_irq;
   } state_type;

   state_type s;
   state_type next_s;
   logic      wr_fire;
   logic      rd_fire;
   logic      done;

   // Address decode, used by read and write paths
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a[1:0] == 2'h0) && ((a >> 4) == '0);
   endfunction

   // Half serial clock period for the rate field
   function automatic logic [7:0] half_div(input logic [1:0] r);
      unique case (r)
         2'h0: half_div = spi_pkg::DIV_00;
         2'h1: half_div = spi_pkg::DIV_01;
         2'h2: half_div = spi_pkg::DIV_10;
         2'h3: half_div = spi_pkg::DIV_11;
      endcase
   endfunction

   // Next state of the whole block
   always_comb begin
      logic en, mstr, cpol, cpha, wom, ss_lvl, ss_used, lead, trail, start, edge_ev;
      logic rx_in, drv_m, drv_s;
      logic [7:0] rd_val, new_sh;
      next_s = s;
      wr_fire = 1'b0;
      rd_fire = 1'b0;
      done = 1'b0;
      rd_val = 8'h00;
      new_sh = 8'h00;
      lead = 1'b0;
      trail = 1'b0;
      start = 1'b0;
      edge_ev = 1'b0;
      rx_in = 1'b0;
      drv_m = 1'b0;
      drv_s = 1'b0;
      ss_used = 1'b0;
      en = s.ctrl[spi_pkg::CTRL_EN];
      mstr = s.ctrl[spi_pkg::CTRL_MSTR];
      cpol = s.ctrl[spi_pkg::CTRL_CPOL];
      cpha = s.ctrl[spi_pkg::CTRL_CPHA];
      wom = s.ctrl[spi_pkg::CTRL_WOM];
      // Two-stage synchronisers on every pin input
      next_s.sck_sync = {s.sck_sync[0], i_serial_clock_pin}; // R26
      next_s.ss_sync = {s.ss_sync[0], i_ss_n}; // R26
      next_s.mosi_sync = {s.mosi_sync[0], i_mosi};
      next_s.miso_sync = {s.miso_sync[0], i_miso};
      next_s.sck_prev = s.sck_sync[1];
      next_s.ss_prev = s.ss_sync[1];
      ss_lvl = s.ss_sync[1];
      // Write address and data channels, taken in either order
      if (s.bvalid && i_s_axi_bready) next_s.bvalid = 1'b0;
      if (i_s_axi_awvalid && s.awready) begin
         next_s.aw_hold = 1'b1;
         next_s.aw_addr = i_s_axi_awaddr;
      end
      if (i_s_axi_wvalid && s.wready) begin
         next_s.w_hold = 1'b1;
         next_s.w_data = i_s_axi_wdata[7:0];
         next_s.w_lane = i_s_axi_wstrb[0];
      end
      if (next_s.aw_hold && next_s.w_hold && !s.bvalid) begin
         wr_fire = 1'b1;
         next_s.aw_hold = 1'b0;
         next_s.w_hold = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = mapped(next_s.aw_addr) ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
      end
      // Read channel
      if (s.rvalid && i_s_axi_rready) next_s.rvalid = 1'b0;
      if (i_s_axi_arvalid && s.arready) begin
         rd_fire = 1'b1;
         unique case (i_s_axi_araddr[3:0])
            spi_pkg::CTRL_OFF: rd_val = s.ctrl & ~(8'h01 << spi_pkg::CTRL_DMA); // R09
            spi_pkg::STAT_OFF: rd_val = {s.rf, s.eie, s.ovf, s.mf, !s.tx_full, s.mfen, s.rate};
            spi_pkg::DATA_OFF: rd_val = s.rx_buf;
            spi_pkg::PORT_OFF: rd_val = {5'h00, ss_lvl, s.ss_dir, s.ss_out};
            default:           rd_val = 8'h00;
         endcase
         if (!mapped(i_s_axi_araddr)) rd_val = 8'h00;
         next_s.rvalid = 1'b1;
         next_s.rdata = rd_val;
         next_s.rresp = mapped(i_s_axi_araddr) ? spi_pkg::RESP_OKAY : spi_pkg::RESP_SLVERR;
         // First step of the two-step flag clears
         if (mapped(i_s_axi_araddr) && i_s_axi_araddr[3:0] == spi_pkg::STAT_OFF) begin
            next_s.rf_arm = s.rf_arm || s.rf; // R15
            next_s.ovf_arm = s.ovf_arm || s.ovf; // R17
            next_s.mf_arm = s.mf_arm || s.mf; // R18
         end
         // Second step: data read clears armed receive flags
         if (mapped(i_s_axi_araddr) && i_s_axi_araddr[3:0] == spi_pkg::DATA_OFF) begin
            if (s.rf_arm) next_s.rf = 1'b0; // R15
            if (s.ovf_arm) next_s.ovf = 1'b0; // R17
            next_s.rf_arm = 1'b0;
            next_s.ovf_arm = 1'b0;
         end
      end
      // Register writes, low byte lane only
      if (wr_fire && next_s.w_lane && mapped(next_s.aw_addr)) begin
         unique case (next_s.aw_addr[3:0])
            spi_pkg::CTRL_OFF: begin
               next_s.ctrl = next_s.w_data & ~(8'h01 << spi_pkg::CTRL_DMA); // R09 R10 R14
               if (s.mf_arm) next_s.mf = 1'b0; // R18
               next_s.mf_arm = 1'b0;
            end
            spi_pkg::STAT_OFF: begin
               next_s.eie = next_s.w_data[spi_pkg::STAT_EIE]; // R16
               next_s.mfen = next_s.w_data[spi_pkg::STAT_MFEN]; // R19
               next_s.rate = next_s.w_data[spi_pkg::STAT_RHI:spi_pkg::STAT_RLO]; // R22
            end
            spi_pkg::DATA_OFF: begin
               next_s.tx_buf = next_s.w_data;
               next_s.tx_full = 1'b1; // R20
            end
            spi_pkg::PORT_OFF: begin
               next_s.ss_out = next_s.w_data[spi_pkg::PORT_SS_OUT];
               next_s.ss_dir = next_s.w_data[spi_pkg::PORT_SS_DIR];
            end
            default: ;
         endcase
      end
      // Serial clock edges seen by a slave
      lead = (s.sck_prev == cpol) && (s.sck_sync[1] != cpol);
      trail = (s.sck_prev != cpol) && (s.sck_sync[1] == cpol);
      rx_in = mstr ? s.miso_sync[1] : s.mosi_sync[1];
      if (en && mstr) begin
         // Master: load the shifter, then divide the clock
         if (!s.active && s.tx_full) begin
            start = 1'b1;
         end else if (s.active) begin
            next_s.div_cnt = s.div_cnt + 8'h01;
            if (s.div_cnt == half_div(s.rate) - 8'h01) begin // R22
               next_s.div_cnt = 8'h00;
               next_s.sck_lvl = !s.sck_lvl;
               edge_ev = 1'b1;
            end
         end
      end else if (en) begin
         if (ss_lvl) begin
            // Deselected slave drops any partial byte
            next_s.active = 1'b0; // R04
            next_s.edge_cnt = 4'h0;
            if (s.active && s.mfen) next_s.mf = 1'b1; // R18 R19
         end else if (!s.active) begin
            start = cpha ? lead : (s.ss_prev && !ss_lvl); // R01 R02
            edge_ev = start && cpha;
         end else begin
            edge_ev = lead || trail;
         end
      end
      if (start) begin
         next_s.active = 1'b1;
         next_s.shift = s.tx_buf;
         next_s.out_bit = s.tx_buf[7];
         next_s.tx_full = 1'b0; // R20
         next_s.edge_cnt = 4'h0;
         next_s.div_cnt = 8'h00;
         next_s.sck_lvl = cpol;
      end
      if (start && wr_fire && next_s.aw_addr[3:0] == spi_pkg::DATA_OFF) next_s.tx_full = 1'b1;
      // Shared shifter: even edges lead, odd edges trail
      if (edge_ev) begin
         next_s.edge_cnt = next_s.edge_cnt + 4'h1;
         if (!next_s.edge_cnt[0] == 1'b0) begin
            if (!cpha) next_s.in_bit = rx_in;
            else next_s.out_bit = next_s.shift[7];
         end else begin
            new_sh = {next_s.shift[6:0], cpha ? rx_in : s.in_bit};
            next_s.shift = new_sh;
            if (!cpha) next_s.out_bit = new_sh[7];
            if (s.edge_cnt == spi_pkg::EDGE_LAST) begin // R25
               done = 1'b1;
               next_s.active = 1'b0;
               if (next_s.rf) next_s.ovf = 1'b1; // R17
               else begin
                  next_s.rx_buf = new_sh;
                  next_s.rf = 1'b1; // R15
               end
            end
         end
      end
      // Master mode fault drops the enable
      if (en && mstr && s.mfen && !ss_lvl) begin
         next_s.mf = 1'b1; // R18
         next_s.ctrl[spi_pkg::CTRL_EN] = 1'b0; // R24
      end
      // Partial reset while disabled
      if (!next_s.ctrl[spi_pkg::CTRL_EN]) begin
         next_s.tx_full = 1'b0; // R23 R14
         next_s.active = 1'b0;
         next_s.shift = 8'h00;
         next_s.edge_cnt = 4'h0;
         next_s.div_cnt = 8'h00;
      end
      if (!next_s.active) next_s.sck_lvl = next_s.ctrl[spi_pkg::CTRL_CPOL];
      // Bus ready flags
      next_s.awready = !next_s.aw_hold && !next_s.bvalid;
      next_s.wready = !next_s.w_hold && !next_s.bvalid;
      next_s.arready = !next_s.rvalid;
      // Pin drivers, open drain under wired-OR
      drv_m = next_s.ctrl[spi_pkg::CTRL_EN] && next_s.ctrl[spi_pkg::CTRL_MSTR];
      drv_s = next_s.ctrl[spi_pkg::CTRL_EN] && !next_s.ctrl[spi_pkg::CTRL_MSTR] && !ss_lvl;
      wom = next_s.ctrl[spi_pkg::CTRL_WOM];
      next_s.sck_o = !wom && next_s.sck_lvl; // R13
      next_s.sck_oe = drv_m && (!wom || !next_s.sck_lvl); // R13
      next_s.mosi_o = !wom && next_s.out_bit;
      next_s.mosi_oe = drv_m && (!wom || !next_s.out_bit);
      next_s.miso_o = !wom && next_s.out_bit;
      next_s.miso_oe = drv_s && (!wom || !next_s.out_bit); // R04
      // Select pin is GPIO only when the SPI does not own it
      ss_used = next_s.ctrl[spi_pkg::CTRL_EN] && (!next_s.ctrl[spi_pkg::CTRL_MSTR] || next_s.mfen);
      next_s.ss_o = next_s.ss_out;
      next_s.ss_oe = !ss_used && next_s.ss_dir; // R03 R05 R06 R07
      // Request lines
      next_s.rx_irq = next_s.rf && next_s.ctrl[spi_pkg::CTRL_RIE]; // R08
      next_s.tx_irq = !next_s.tx_full && next_s.ctrl[spi_pkg::CTRL_TIE]
                      && next_s.ctrl[spi_pkg::CTRL_EN]; // R08
      next_s.err_irq = next_s.eie && (next_s.ovf || next_s.mf); // R16
   end

   // State register with synchronous reset
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         s <= '0;
         s.ctrl <= spi_pkg::CTRL_RESET; // R10 R11
         s.sck_sync <= 2'h0;
         s.ss_sync <= 2'h3;
         s.ss_prev <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign o_s_axi_awready = s.awready;
   assign o_s_axi_wready = s.wready;
   assign o_s_axi_bresp = s.bresp;
   assign o_s_axi_bvalid = s.bvalid;
   assign o_s_axi_arready = s.arready;
   assign o_s_axi_rdata = {24'h000000, s.rdata};
   assign o_s_axi_rresp = s.rresp;
   assign o_s_axi_rvalid = s.rvalid;
   assign o_serial_clock_pin = s.sck_o;
   assign o_serial_clock_pin_oe = s.sck_oe;
   assign o_mosi = s.mosi_o;
   assign o_mosi_oe = s.mosi_oe;
   assign o_miso = s.miso_o;
   assign o_miso_oe = s.miso_oe;
   assign o_ss_n = s.ss_o;
   assign o_ss_n_oe = s.ss_oe;
   assign o_rx_irq = s.rx_irq;
   assign o_tx_irq = s.tx_irq;
   assign o_err_irq = s.err_irq;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_half_gap;
      (!$changed(s.sck_lvl))[*7] ##1 ($changed(s.sck_lvl) || !s.active);
   endsequence
   property p_rate_fast;
      $changed(s.sck_lvl) && s.active && s.rate == 2'h1 |=> s_half_gap;
   endproperty
   a_rate_fast: assert property (p_rate_fast) else $error("half period not 8"); // R22
   property p_dma_zero;
      rd_fire && i_s_axi_araddr[3:0] == spi_pkg::CTRL_OFF |=> !o_s_axi_rdata[spi_pkg::CTRL_DMA];
   endproperty
   a_dma_zero: assert property (p_dma_zero) else $error("DMA bit read as one"); // R09
   property p_desel;
      s.ctrl[spi_pkg::CTRL_EN] && !s.ctrl[spi_pkg::CTRL_MSTR] && s.ss_sync[1] |=> !o_miso_oe;
   endproperty
   a_desel: assert property (p_desel) else $error("MISO driven while deselected"); // R04
   property p_reset_val;
      @(posedge i_ref_clk) i_rst |=> s.ctrl[spi_pkg::CTRL_MSTR] && s.ctrl[spi_pkg::CTRL_CPHA]
         && !s.ctrl[spi_pkg::CTRL_CPOL] && !s.ctrl[spi_pkg::CTRL_EN] && !s.tx_full;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("bad reset values"); // R10
   property p_ovf;
      done && s.rf && !(rd_fire && s.rf_arm) |=> s.ovf && $stable(s.rx_buf);
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow not handled"); // R17
   property p_mfault;
      s.ctrl[spi_pkg::CTRL_EN] && s.ctrl[spi_pkg::CTRL_MSTR] && s.mfen && !s.ss_sync[1]
         |=> s.mf && !s.ctrl[spi_pkg::CTRL_EN] ##1 !o_serial_clock_pin_oe;
   endproperty
   a_mfault: assert property (p_mfault) else $error("master fault missed"); // R24
   property p_disabled;
      !s.ctrl[spi_pkg::CTRL_EN] |-> !s.tx_full && !s.active && s.edge_cnt == 4'h0;
   endproperty
   a_disabled: assert property (p_disabled) else $error("disabled state not cleared"); // R23
   property p_no_fault;
      !s.mfen && !s.mf && !wr_fire |=> !s.mf;
   endproperty
   a_no_fault: assert property (p_no_fault) else $error("fault set while disabled"); // R19
   property p_wired;
      s.ctrl[spi_pkg::CTRL_WOM] && o_serial_clock_pin_oe |-> !o_serial_clock_pin;
   endproperty
   a_wired: assert property (p_wired) else $error("open drain drove high"); // R13
   property p_tx_irq;
      o_tx_irq |-> s.ctrl[spi_pkg::CTRL_EN] && !s.tx_full && s.ctrl[spi_pkg::CTRL_TIE];
   endproperty
   a_tx_irq: assert property (p_tx_irq) else $error("transmit request ungated"); // R08
endmodule
